// ===== core/core_launch_defs.svh
// Constants for the core launch and stop control.
// Assumes it is included by bare name; definitions only.
`ifndef CORE_LAUNCH_DEFS_SVH
`define CORE_LAUNCH_DEFS_SVH
`define CORE_COUNT        8
`define CORE_ID_W         3
`define ADDR_W            16
`define BOOT_PARAM_W      14
`define BOOT_PARAM_LSB    2
`define BOOT_PARAM_MSB    15
`define RESULT_W          4
`define RESULT_NONE       4'hF
`define LOAD_WORDS        8'h10
`define LOAD_CNT_W        8
`define LOAD_CNT_ONE      8'h01
`define LOAD_CNT_ZERO     8'h00
`endif

// ===== core/core_launch_pkg.sv
// Types shared by the launch control and its slot table.
// Assumes core_launch_defs.svh is on the include path.
`include "core_launch_defs.svh"
package core_launch_pkg;
   typedef logic [`CORE_ID_W-1:0]    core_id_t;
   typedef logic [`CORE_COUNT-1:0]   core_mask_t;
   typedef logic [`ADDR_W-1:0]       hub_addr_t;
   typedef logic [`BOOT_PARAM_W-1:0] boot_param_t;
   typedef logic [`RESULT_W-1:0]     launch_result_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_LOAD = 3'h2,
      ST_DONE = 3'h4
   } loader_state_t;
endpackage : core_launch_pkg

// ===== core/core_slot_table.sv
// Per-core memory of boot parameter and start address, registered read.
// Assumes one writer per cycle and a single system clock.
`timescale 1ns/1ps
module core_slot_table (
   input  wire logic                         clk_sys_i,
   input  wire logic                         clk_en_i,
   input  wire logic                         wr_en_i,
   input  wire core_launch_pkg::core_id_t    wr_id_i,
   input  wire core_launch_pkg::boot_param_t wr_param_i,
   input  wire core_launch_pkg::hub_addr_t   wr_addr_i,
   input  wire core_launch_pkg::core_id_t    rd_id_i,
   output core_launch_pkg::boot_param_t      rd_param_o,
   output core_launch_pkg::hub_addr_t        rd_addr_o
);
   import core_launch_pkg::*;

   boot_param_t param_mem [`CORE_COUNT];
   hub_addr_t   addr_mem  [`CORE_COUNT];

   always_ff @(posedge clk_sys_i) begin
      if (clk_en_i && wr_en_i) begin
         param_mem[wr_id_i] <= wr_param_i;
         addr_mem[wr_id_i]  <= wr_addr_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clk_en_i) begin
         rd_param_o <= param_mem[rd_id_i];
         rd_addr_o  <= addr_mem[rd_id_i];
      end
   end
endmodule : core_slot_table

// ===== core/core_launch_stop_control.sv
// Hub-side allocator that launches and stops the eight processor cores.
// Assumes requests are synchronous to clk_sys_i and one-cycle pulses.
// Assumes the loader answers load_req_o with one load_ack_i pulse per accepted word.
`timescale 1ns/1ps
`include "core_launch_defs.svh"
module core_launch_stop_control (
   input  wire logic                             clk_sys_i,
   input  wire logic                             sys_rst_i,
   input  wire logic                             clk_en_i,
   input  wire logic                             launch_req_i,
   input  wire logic                             launch_is_method_i,
   input  wire core_launch_pkg::hub_addr_t       code_start_address_i,
   input  wire logic [31:0]                      launch_param_i,
   input  wire core_launch_pkg::hub_addr_t       stack_base_pointer_i,
   input  wire logic                             stop_req_i,
   input  wire core_launch_pkg::core_id_t        stop_id_i,
   input  wire logic                             load_ack_i,
   output logic                                  launch_done_o,
   output core_launch_pkg::launch_result_t       launch_result_o,
   output core_launch_pkg::core_mask_t           core_busy_o,
   output core_launch_pkg::core_mask_t           core_clk_en_o,
   output core_launch_pkg::core_mask_t           core_run_o,
   output logic                                  load_req_o,
   output core_launch_pkg::core_id_t             load_id_o,
   output core_launch_pkg::hub_addr_t            load_addr_o,
   output logic                                  load_is_method_o,
   output core_launch_pkg::boot_param_t          boot_parameter_register_o,
   output core_launch_pkg::hub_addr_t            boot_code_address_o
);
   import core_launch_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Allocation.

   function automatic core_id_t lowest_free(input core_mask_t busy);
      core_id_t id;
      id = '0;
      // Scanning downwards leaves the lowest free index as the last one written.
      for (int i = `CORE_COUNT - 1; i >= 0; i--) begin
         if (!busy[i]) begin
            id = core_id_t'(i);
         end
      end
      return id;
   endfunction : lowest_free

   function automatic core_mask_t id_onehot(input core_id_t id);
      core_mask_t m;
      m = '0;
      m[id] = 1'b1;
      return m;
   endfunction : id_onehot

   core_mask_t      busy_r;
   core_mask_t      run_r;
   core_mask_t      busy_nxt;
   core_mask_t      run_nxt;
   loader_state_t   state_r;
   loader_state_t   state_nxt;
   core_id_t        load_id_r;
   hub_addr_t       load_addr_r;
   logic            load_method_r;
   logic [`LOAD_CNT_W-1:0] load_cnt_r;
   launch_result_t  result_r;
   logic            done_r;

   wire        any_free   = ~&busy_r;
   wire core_id_t pick_id = lowest_free(busy_r);
   // A launch is refused while the loader is busy or no core is free; the result still returns at once.
   wire        launch_ok  = launch_req_i && any_free && (state_r == ST_IDLE);
   wire        launch_no  = launch_req_i && !launch_ok;
   wire core_mask_t stop_mask = stop_req_i ? id_onehot(stop_id_i) : '0;
   wire core_mask_t pick_mask = launch_ok ? id_onehot(pick_id) : '0;
   // A stop aimed at the core under load cancels its word request in the same cycle.
   wire        stop_loading = stop_req_i && (stop_id_i == load_id_r) && (state_r != ST_IDLE);
   // The counter starts at one with the launch, so the word that meets the limit is the last.
   wire        load_last  = load_ack_i && (load_cnt_r == `LOAD_WORDS);
   wire        load_step  = (state_r == ST_LOAD) && load_ack_i && !load_last;
   // A core only starts running if it is still allocated when its load completes.
   wire core_mask_t done_mask = (state_r == ST_DONE && busy_r[load_id_r]) ? id_onehot(load_id_r) : '0;
   wire boot_param_t param_kept = launch_param_i[`BOOT_PARAM_MSB:`BOOT_PARAM_LSB];
   wire boot_param_t stack_kept = stack_base_pointer_i[`BOOT_PARAM_MSB:`BOOT_PARAM_LSB];
   wire boot_param_t param_sel  = launch_is_method_i ? stack_kept : param_kept;

   ////////////////////////////////////////////////////////////////////////////
   // Loader sequencing.

   // One load runs at a time; a second launch is refused until the loader is back in idle.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (launch_ok) begin
               state_nxt = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (stop_loading) begin
               state_nxt = ST_IDLE;
            end else if (load_last) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-core allocation and run bits.
   //
   // Every core owns one slice, so a stop aimed at one core never disturbs the
   // allocation or execution of another. A stop that meets the end of the same
   // core's load still wins; otherwise that core would run with its clock gated off.

   genvar g;
   generate
      for (g = 0; g < `CORE_COUNT; g = g + 1) begin : g_core
         wire stop_hit  = stop_mask[g];
         wire pick_hit  = pick_mask[g];
         wire start_hit = done_mask[g];

         // A launch only picks a free core, so a pick never meets a stop of a busy core.
         assign busy_nxt[g]      = (busy_r[g] && !stop_hit) || pick_hit;
         assign run_nxt[g]       = ((run_r[g] && !pick_hit) || start_hit) && !stop_hit;
         assign core_clk_en_o[g] = busy_r[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Registered state.

   // A low clock enable freezes every register here, including the loader state.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         busy_r  <= '0;
         run_r   <= '0;
         state_r <= ST_IDLE;
      end else if (clk_en_i) begin
         busy_r  <= busy_nxt;
         run_r   <= run_nxt;
         state_r <= state_nxt;
      end
   end

   // The answer is registered so that it stands for the whole cycle after the request.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         result_r <= '0;
         done_r   <= 1'b0;
      end else if (clk_en_i) begin
         done_r <= launch_req_i;
         if (launch_ok) begin
            result_r <= {1'b0, pick_id};
         end else if (launch_no) begin
            result_r <= `RESULT_NONE;
         end
      end
   end

   // Only an accepted launch writes the load descriptor, so a refused one leaves the current load alone.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         load_id_r     <= '0;
         load_addr_r   <= '0;
         load_method_r <= 1'b0;
      end else if (clk_en_i && launch_ok) begin
         load_id_r     <= pick_id;
         load_addr_r   <= code_start_address_i;
         load_method_r <= launch_is_method_i;
      end
   end

   // The word counter is loaded by an accepted launch and moves on accepted words; a frozen cycle leaves it alone.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         load_cnt_r <= `LOAD_CNT_ZERO;
      end else if (clk_en_i) begin
         if (launch_ok) begin
            load_cnt_r <= `LOAD_CNT_ONE;
         end else if (load_step) begin
            load_cnt_r <= load_cnt_r + `LOAD_CNT_ONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-core boot data.

   // Written by the accepted launch and read back for the core under load, one cycle late.
   core_slot_table i_core_slot_table (
      .clk_sys_i  (clk_sys_i),
      .clk_en_i   (clk_en_i),
      .wr_en_i    (launch_ok),
      .wr_id_i    (pick_id),
      .wr_param_i (param_sel),
      .wr_addr_i  (code_start_address_i),
      .rd_id_i    (load_id_r),
      .rd_param_o (boot_parameter_register_o),
      .rd_addr_o  (boot_code_address_o)
   );

   assign launch_done_o    = done_r;
   assign launch_result_o  = result_r;
   assign core_busy_o      = busy_r;
   assign core_run_o       = run_r;
   assign load_req_o       = (state_r == ST_LOAD) && !stop_loading;
   assign load_id_o        = load_id_r;
   assign load_addr_o      = load_addr_r;
   assign load_is_method_o = load_method_r;
endmodule : core_launch_stop_control

// ===== verification/loader_model.sv
// Hub loader partner: grants code-load words to the control.
// Assumes the control's clock; slow_i halves the grant rate.
`timescale 1ns/1ps
module loader_model (
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   input  wire logic slow_i,
   input  wire logic load_req_i,
   output logic      load_ack_o
);
   logic phase_r;
   // A busy hub grants only every other cycle, so loads take twice as long.
   always_ff @(posedge clk_sys_i) begin
      phase_r <= sys_rst_i ? 1'b0 : (!slow_i || !phase_r);
   end
   assign load_ack_o = load_req_i && phase_r;
endmodule : loader_model

// ===== verification/core_launch_stop_control_chk.sv
// Port assertions for the core launch and stop control.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module core_launch_stop_control_chk (
   input wire logic                           clk_sys_i,
   input wire logic                           sys_rst_i,
   input wire logic                           clk_en_i,
   input wire logic                           launch_req_i,
   input wire logic                           stop_req_i,
   input wire core_launch_pkg::core_id_t      stop_id_i,
   input wire logic                           launch_done_o,
   input wire core_launch_pkg::launch_result_t launch_result_o,
   input wire core_launch_pkg::core_mask_t    core_busy_o,
   input wire core_launch_pkg::core_mask_t    core_clk_en_o,
   input wire core_launch_pkg::core_mask_t    core_run_o,
   input wire logic                           load_req_o,
   input wire core_launch_pkg::core_id_t      load_id_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic take;
   assign take = launch_req_i && clk_en_i;
   property p_done; take |=> launch_done_o; endproperty
   a_done: assert property (p_done) else $error("launch not answered");
   property p_quiet;
      clk_en_i && !launch_req_i |=> !launch_done_o && $stable(launch_result_o);
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_id;
      launch_done_o && launch_result_o != 4'hF |-> core_busy_o[launch_result_o[2:0]];
   endproperty
   a_id: assert property (p_id) else $error("returned core not allocated");
   property p_none; take && (&core_busy_o) |=> launch_result_o == 4'hF; endproperty
   a_none: assert property (p_none) else $error("full launch not refused");
   property p_busy;
      take && load_req_o && !stop_req_i |=> launch_result_o == 4'hF && $stable(core_busy_o);
   endproperty
   a_busy: assert property (p_busy) else $error("launch during load not refused");
   property p_clk; core_clk_en_o == core_busy_o; endproperty
   a_clk: assert property (p_clk) else $error("clock enable differs from busy");
   property p_stop;
      stop_req_i && clk_en_i && core_busy_o[stop_id_i] |=>
         !core_busy_o[$past(stop_id_i)] && !core_clk_en_o[$past(stop_id_i)] && !core_run_o[$past(stop_id_i)];
   endproperty
   a_stop: assert property (p_stop) else $error("stopped core still busy");
   property p_load; load_req_o |-> core_busy_o[load_id_o] && !core_run_o[load_id_o]; endproperty
   a_load: assert property (p_load) else $error("load of idle or running core");
   c_ok: cover property (take ##1 launch_result_o != 4'hF);
   c_full: cover property (take && (&core_busy_o));
   c_stop: cover property (stop_req_i && core_busy_o[stop_id_i]);
endmodule : core_launch_stop_control_chk
bind core_launch_stop_control core_launch_stop_control_chk i_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
   .clk_en_i(clk_en_i), .launch_req_i(launch_req_i), .stop_req_i(stop_req_i), .stop_id_i(stop_id_i),
   .launch_done_o(launch_done_o), .launch_result_o(launch_result_o), .core_busy_o(core_busy_o),
   .core_clk_en_o(core_clk_en_o), .core_run_o(core_run_o), .load_req_o(load_req_o), .load_id_o(load_id_o));

// ===== verification/core_launch_stop_control_tb.sv
// Self-checking bench for the launch and stop control.
// Assumes loader_model answers the code-load words.
`timescale 1ns/1ps
module core_launch_stop_control_tb;
   import core_launch_pkg::*;
   logic           clk, rst, en, req, meth, stop, slow, ack, done, lreq, lmeth;
   logic [31:0]    param;
   hub_addr_t      addr, sp, laddr, bcaddr;
   core_id_t       stop_id, lid;
   launch_result_t result;
   core_mask_t     busy, clken, run;
   boot_param_t    boot;
   int             n_errors = 0;
   int             num_checks = 0;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   core_launch_stop_control i_core_launch_stop_control (.clk_sys_i(clk), .sys_rst_i(rst), .clk_en_i(en),
      .launch_req_i(req), .launch_is_method_i(meth), .code_start_address_i(addr), .launch_param_i(param),
      .stack_base_pointer_i(sp), .stop_req_i(stop), .stop_id_i(stop_id), .load_ack_i(ack), .launch_done_o(done),
      .launch_result_o(result), .core_busy_o(busy), .core_clk_en_o(clken), .core_run_o(run), .load_req_o(lreq),
      .load_id_o(lid), .load_addr_o(laddr), .load_is_method_o(lmeth), .boot_parameter_register_o(boot),
      .boot_code_address_o(bcaddr));
   loader_model i_loader_model (.clk_sys_i(clk), .sys_rst_i(rst), .slow_i(slow), .load_req_i(lreq),
      .load_ack_o(ack));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic launch(input logic m, input logic [31:0] p, input launch_result_t exp);
      boot_param_t eb;
      @(negedge clk);
      req = 1'b1;
      meth = m;
      param = p;
      sp = ~p[15:0];
      addr = p[31:16];
      eb = m ? sp[15:2] : p[15:2];
      @(negedge clk);
      req = 1'b0;
      chk(done, 16'h0001);
      chk(result, exp);
      if (exp != 4'hF) begin
         @(negedge clk);
         chk(boot, eb);
         chk(laddr, p[31:16]);
         chk(bcaddr, p[31:16]);
         chk(lid, exp[2:0]);
         chk(lmeth, m);
         chk(lreq, 16'h0001);
         chk(run[exp[2:0]], 1'b0);
      end
   endtask : launch
   task automatic wait_run(input int id);
      int i;
      for (i = 0; i < 100 && run[id] !== 1'b1; i++) @(negedge clk);
      chk(run[id], 1'b1);
      if (i == 100) end_of_test();
   endtask : wait_run
   task automatic halt(input core_id_t id);
      @(negedge clk);
      stop = 1'b1;
      stop_id = id;
      @(negedge clk);
      stop = 1'b0;
      chk({busy[id], clken[id], run[id]}, 16'h0000);
   endtask : halt
   task automatic t_fill();
      for (int k = 0; k < 8; k++) begin
         slow = k[1];
         launch(k[0], 32'h1000A5A7 + k * 32'h00010104, 4'(k));
         wait_run(k);
      end
      chk(clken, 16'h00FF);
      launch(1'b0, 32'h0, 4'hF);
      chk(busy, 16'h00FF);
      $display("fill and full test done");
   endtask : t_fill
   task automatic t_stop();
      halt(3'h3);
      halt(3'h5);
      launch(1'b1, 32'h22227FFC, 4'h3);
      launch(1'b0, 32'h00000004, 4'hF);
      wait_run(3);
      launch(1'b0, 32'hFFFFFFFF, 4'h5);
      halt(3'h5);
      chk(lreq, 16'h0000);
      launch(1'b0, 32'h33330008, 4'h5);
      wait_run(5);
      $display("stop and relaunch test done");
   endtask : t_stop
   // A request held while the clock enable is low must be ignored and the load must pause.
   task automatic t_freeze();
      halt(3'h6);
      launch(1'b0, 32'h44440010, 4'h6);
      @(negedge clk);
      en = 1'b0;
      req = 1'b1;
      repeat (4) @(negedge clk);
      chk(done, 16'h0000);
      chk(result, 16'h0006);
      chk(busy, 16'h00FF);
      chk(run[6], 1'b0);
      en = 1'b1;
      req = 1'b0;
      wait_run(6);
      $display("clock enable freeze test done");
   endtask : t_freeze
   initial begin
      rst = 1'b1;
      en = 1'b1;
      req = 1'b0;
      meth = 1'b0;
      stop = 1'b0;
      slow = 1'b0;
      param = '0;
      addr = '0;
      sp = '0;
      stop_id = '0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      chk(busy, 16'h0000);
      t_fill();
      t_stop();
      t_freeze();
      end_of_test();
   end
endmodule : core_launch_stop_control_tb
